// [rtl/interval_counter.sv]
/*
  Down counter that times minimum intervals for the sequencer.
  Assumes load comes from logic on the same clock.
*/
module interval_counter (
  input wire logic clock,
  input wire logic nrst,
  sram_host_if.cnt ctl
);
  logic [3:0] count_reg;
  logic [3:0] count_next;

  assign count_next = ctl.load ? ctl.loadValue :
                      (count_reg != 4'h0) ? count_reg - 4'h1 : count_reg;
  // Done ignores load, so ready, take and load form no combinational loop.
  assign ctl.done = (count_reg == 4'h0);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule // interval_counter

// [rtl/sram_host.sv]
/*
  Host controller for a 128K by 8 asynchronous static memory.
  Assumes the memory pins connect directly and the bench resolves the data
  wire from dataOe; supplyLow marks that the supply sits at retention level.
*/
// How it works
// R1: 17-bit address, 8-bit two-way data bus.
// R2: Select needs low select and high select.
// R3: Memory floats bus when off or writing.
// R4: Write: select with strobe low stores byte.
// R5: Read: select, enable low, strobe high.
// R6: Deselected memory idles in standby, keeps data.
// R7: Data valid 45 ns after address.
// R8: Old data held 10 ns after address.
// R9: Data valid 45 ns after select.
// R10: Data valid 22 ns after enable low.
// R11: Standby reached 45 ns after deselect.
// R12: Address stable 35 ns before write end.
// R13: Address present by write start.
// R14: Address may change at write end.
// R15: Data driven 25 ns before write end.
// R16: Wait 45 ns after supply recovery.
// R17: Deselect before supply is lowered.
// R18: Write is overlap of strobe and select.
// R19: Selected, strobe and enable high: bus floats.
// R20: Count cycles covering every minimum interval.
module sram_host (
  input wire logic clock,
  input wire logic nrst,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [16:0] reqAddr,
  input wire logic [7:0] reqData,
  output logic rspValid,
  output logic [7:0] rspData,
  input wire logic supplyLow,
  output logic [16:0] memAddr,
  output logic selectActiveLowN,
  output logic selectActiveHigh,
  output logic outEnableN,
  output logic writeStrobeN,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe
);
  sram_host_if tim ();
  sram_host_pkg::state_type state_reg;
  sram_host_pkg::state_type state_next;
  logic [16:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [7:0] dataSync1_reg;
  logic [7:0] dataSync2_reg;
  logic [1:0] lowSync_reg;
  logic lowSeen_reg;
  logic start;
  logic selected;
  logic rdDone;

  // ****************************************************************
  // Pin input synchronisers
  // ****************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dataSync1_reg <= 8'h00;
      dataSync2_reg <= 8'h00;
      lowSync_reg <= 2'b11;
    end else begin
      dataSync1_reg <= dataIn;
      dataSync2_reg <= dataSync1_reg;
      lowSync_reg <= {lowSync_reg[0], supplyLow};
    end
  end

  interval_counter u_counter (
    .clock(clock),
    .nrst(nrst),
    .ctl(tim.cnt)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Supply is assumed low at reset, so the recovery wait always runs first.
  assign reqReady = (state_reg == sram_host_pkg::IDLE) && !lowSync_reg[1]
                    && !lowSeen_reg && tim.done; // R16
  assign start = reqValid && reqReady;
  assign rdDone = (state_reg == sram_host_pkg::READ) && tim.done;

  always_comb begin
    state_next = state_reg;
    tim.load = 1'b0;
    tim.loadValue = 4'h0;
    case (state_reg)
      sram_host_pkg::IDLE: begin
        if (lowSeen_reg && !lowSync_reg[1]) begin
          state_next = sram_host_pkg::RECOVER;
          tim.load = 1'b1;
          tim.loadValue = 4'(sram_host_pkg::RECOVERY_CYCLES - 1); // R16
        end else if (start && reqWrite) begin
          state_next = sram_host_pkg::WRITE;
          tim.load = 1'b1;
          tim.loadValue = 4'(sram_host_pkg::WRITE_CYCLES - 1); // R20
        end else if (start) begin
          state_next = sram_host_pkg::READ;
          tim.load = 1'b1;
          tim.loadValue = 4'(sram_host_pkg::READ_CYCLES - 1); // R7 R9
        end
      end
      sram_host_pkg::RECOVER: begin
        if (tim.done) begin
          state_next = sram_host_pkg::IDLE;
        end
      end
      sram_host_pkg::READ: begin
        if (tim.done) begin
          state_next = sram_host_pkg::TURN;
          tim.load = 1'b1;
          tim.loadValue = 4'(sram_host_pkg::DRIVE_OFF_CYCLES - 1); // R20
        end
      end
      sram_host_pkg::WRITE: begin
        if (tim.done) begin
          state_next = sram_host_pkg::IDLE;
        end
      end
      sram_host_pkg::TURN: begin
        // Lets the memory release the bus before any later write drives it.
        if (tim.done) begin
          state_next = sram_host_pkg::IDLE;
        end
      end
      default: begin
        state_next = sram_host_pkg::IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= sram_host_pkg::IDLE;
      lowSeen_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (lowSync_reg[1]) begin
        lowSeen_reg <= 1'b1;
      end else if (state_reg == sram_host_pkg::RECOVER) begin
        lowSeen_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Address, data and response registers
  // ****************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= 17'h0_0000;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      if (start) begin
        addr_reg <= reqAddr; // R13
        wdata_reg <= reqData;
      end
      if (rdDone) begin
        rdata_reg <= dataSync2_reg; // R5
      end
      rvalid_reg <= rdDone;
    end
  end

  // ****************************************************************
  // Memory pins
  // ****************************************************************
  // Address stays put after a cycle ends, which covers every hold time.
  assign selected = (state_reg == sram_host_pkg::READ) ||
                    (state_reg == sram_host_pkg::WRITE);
  assign memAddr = addr_reg; // R1 R12 R14
  assign selectActiveLowN = !selected; // R2 R17
  assign selectActiveHigh = selected; // R2
  assign outEnableN = !(state_reg == sram_host_pkg::READ); // R5 R10
  assign writeStrobeN = !(state_reg == sram_host_pkg::WRITE); // R4 R18
  assign dataOut = wdata_reg; // R15
  assign dataOe = (state_reg == sram_host_pkg::WRITE); // R3
  assign rspValid = rvalid_reg;
  assign rspData = rdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_writeLength;
    @(posedge clock) disable iff (!nrst)
      $fell(writeStrobeN) |-> !writeStrobeN [*5] ##1 writeStrobeN;
  endproperty
  a_writeLength: assert property (p_writeLength) // R12
    else $error("Write strobe not held five cycles.");

  property p_dataWithStrobe;
    @(posedge clock) disable iff (!nrst)
      !writeStrobeN |-> dataOe && !selectActiveLowN &&
        ($fell(writeStrobeN) || $stable(dataOut));
  endproperty
  a_dataWithStrobe: assert property (p_dataWithStrobe) // R15
    else $error("Write data not driven through the strobe.");

  property p_addrStable;
    @(posedge clock) disable iff (!nrst)
      !selectActiveLowN && !$fell(selectActiveLowN) |-> $stable(memAddr);
  endproperty
  a_addrStable: assert property (p_addrStable) // R13
    else $error("Address moved while selected.");

  property p_noClash;
    @(posedge clock) disable iff (!nrst)
      !(dataOe && !outEnableN);
  endproperty
  a_noClash: assert property (p_noClash) // R3
    else $error("Host drives while memory outputs enabled.");

  property p_readLength;
    @(posedge clock) disable iff (!nrst)
      $fell(outEnableN) |-> !outEnableN [*8] ##1 rspValid;
  endproperty
  a_readLength: assert property (p_readLength) // R7
    else $error("Read did not last the access time.");

  property p_turnAround;
    @(posedge clock) disable iff (!nrst)
      $rose(outEnableN) |-> !dataOe [*3];
  endproperty
  a_turnAround: assert property (p_turnAround) // R20
    else $error("Bus driven too soon after a read.");

  property p_selectPair;
    @(posedge clock) disable iff (!nrst)
      selectActiveHigh == !selectActiveLowN;
  endproperty
  a_selectPair: assert property (p_selectPair) // R2
    else $error("Select pins disagree.");

  property p_supplyIdle;
    @(posedge clock) disable iff (!nrst)
      lowSync_reg[1] |-> selectActiveLowN || $past(lowSync_reg[1]) == 1'b0;
  endproperty
  a_supplyIdle: assert property (p_supplyIdle) // R17
    else $error("Selected while supply low.");

  property p_recovery;
    @(posedge clock) disable iff (!nrst)
      $fell(lowSync_reg[1]) |-> !reqReady [*6];
  endproperty
  a_recovery: assert property (p_recovery) // R16
    else $error("Ready before recovery time.");
endmodule // sram_host

// [rtl/sram_host_if.sv]
/*
  Bundle between the sequencer and its interval counter.
  Assumes both ends share one clock.
*/
interface sram_host_if;
  logic load;
  logic [3:0] loadValue;
  logic done;
  modport seq (output load, output loadValue, input done);
  modport cnt (input load, input loadValue, output done);
endinterface

// [rtl/sram_host_pkg.sv]
/*
  Constants shared by the asynchronous static memory host controller.
  Assumes a single 125 MHz clock and the memory wired straight to pins.
*/
package sram_host_pkg;

  // ****************************************************************
  // Widths and clock period
  // ****************************************************************
  localparam int ADDR_WIDTH = 17;
  localparam int DATA_WIDTH = 8;
  localparam int CLOCK_PERIOD_PS = 8000;

  // ****************************************************************
  // Pin timing in nanoseconds and derived cycle counts
  // ****************************************************************
  localparam int READ_CYCLE_NS = 45;
  localparam int ADDR_ACCESS_NS = 45;
  localparam int SELECT_ACCESS_NS = 45;
  localparam int ENABLE_ACCESS_NS = 22;
  localparam int WRITE_CYCLE_NS = 45;
  localparam int WRITE_PULSE_NS = 35;
  localparam int ADDR_TO_WRITE_END_NS = 35;
  localparam int DATA_SETUP_NS = 25;
  localparam int DRIVE_OFF_NS = 18;
  localparam int RECOVERY_NS = 45;
  localparam int POWER_DOWN_NS = 45;

  function automatic int ceilCycles(input int ns);
    int c;
    c = (ns * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Two extra cycles let returning data pass both capture flops.
  localparam int READ_CYCLES = ceilCycles(ADDR_ACCESS_NS) + 2;
  localparam int WRITE_CYCLES = ceilCycles(WRITE_PULSE_NS);
  localparam int DRIVE_OFF_CYCLES = ceilCycles(DRIVE_OFF_NS);
  localparam int RECOVERY_CYCLES = ceilCycles(RECOVERY_NS);
  localparam int COUNT_WIDTH = 4;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    RECOVER = 3'b001,
    READ = 3'b010,
    WRITE = 3'b011,
    TURN = 3'b100
  } state_type;

endpackage

// [tb/sram_model.sv]
/*
  Behavioural 128K by 8 asynchronous static memory for the host bench.
  Assumes the bench resolves the shared data wire from hostDrive.
*/
module sram_model (
  input wire logic [16:0] addr,
  input wire logic selectActiveLowN,
  input wire logic selectActiveHigh,
  input wire logic outEnableN,
  input wire logic writeStrobeN,
  input wire logic hostDrive,
  input wire logic [7:0] hostData,
  input wire logic supplyLow,
  output logic [7:0] busOut,
  output logic fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:131071];
  logic [7:0] oldData;
  time tAddr, tSel, tOe, tWr, tData, tUp;
  wire selected = !selectActiveLowN && selectActiveHigh;
  wire writing = selected && !writeStrobeN;
  wire reading = selected && !outEnableN && writeStrobeN;
  initial begin
    fault = 0;
    busOut = 8'h00;
    {tAddr, tSel, tOe, tWr, tData, tUp} = '0;
  end
  always @(addr) begin
    oldData = busOut;
    tAddr = $time;
  end
  always @(posedge selected) tSel = $time;
  always @(negedge outEnableN) tOe = $time;
  always @(hostData) tData = $time;
  always @(negedge supplyLow) tUp = $time;
  always @(posedge supplyLow) if (selected) fault = 1;
  always @(posedge reading) if ($time - tUp < 45) fault = 1;
  always @(posedge writing) begin
    tWr = $time;
    if ($time - tUp < 45) fault = 1;
    // Strobe and drive rise together; look once both have settled.
    #1ps if (!hostDrive) fault = 1;
  end
  // Dropping the drive at the strobe's own edge is a legal zero hold.
  always @(negedge hostDrive) #1ps if (writing) fault = 1;
  // The byte is taken at the edge that ends the overlap of strobe and select.
  always @(negedge writing) begin
    if ($time - tWr < 35 || $time - tData < 25 || $time - tAddr < 35)
      fault = 1;
    mem[addr] = hostData;
  end
  always @(posedge hostDrive) if (reading) fault = 1;
  // A bus nobody drives shows a pattern that changes every nanosecond.
  always #1 begin
    if (reading && $time - tAddr >= 45 && $time - tSel >= 45
        && $time - tOe >= 22) busOut = mem[addr];
    else if (reading && $time - tAddr < 10) busOut = oldData;
    else busOut = ~busOut;
  end
endmodule // sram_model

// [tb/tb_sram_host.sv]
/*
  Self-checking bench for the static memory host controller.
  Assumes the design and the memory model are compiled before it.
*/
module tb_sram_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, nrst = 0, reqValid = 0, reqWrite = 0, supplyLow = 0;
  logic [16:0] reqAddr = '0;
  logic [7:0] reqData = '0;
  logic reqReady, rspValid, selN, selH, oeN, weN, dataOe, fault;
  logic [16:0] memAddr;
  logic [7:0] rspData, dataOut, busOut, dataIn;
  logic [7:0] expQ [$];
  logic [7:0] refMem [int];
  logic [16:0] used [$];
  int num_errors = 0, checks_done = 0;
  assign dataIn = dataOe ? dataOut : busOut;
  always #4 clock = ~clock;
  sram_host u_dut (.clock(clock), .nrst(nrst), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
    .supplyLow(supplyLow), .memAddr(memAddr), .selectActiveLowN(selN),
    .selectActiveHigh(selH), .outEnableN(oeN), .writeStrobeN(weN),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
  sram_model u_mem (.addr(memAddr), .selectActiveLowN(selN),
    .selectActiveHigh(selH), .outEnableN(oeN), .writeStrobeN(weN),
    .hostDrive(dataOe), .hostData(dataOut), .supplyLow(supplyLow),
    .busOut(busOut), .fault(fault));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Holds the request until the ready seen in the cycle before an edge.
  task automatic req(logic w, logic [16:0] a, logic [7:0] d);
    logic rdy;
    int n;
    n = 0;
    reqValid <= 1;
    reqWrite <= w;
    reqAddr <= a;
    reqData <= d;
    do begin
      @(negedge clock) rdy = reqReady;
      @(posedge clock);
      n++;
    end while (rdy !== 1'b1 && n < 200);
    if (n >= 200) check("request taken", 0, 1);
    if (w) refMem[a] = d;
    else expQ.push_back(refMem[a]);
    if (w) used.push_back(a);
  endtask
  task automatic idle(int cycles);
    reqValid <= 0;
    repeat (cycles) @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (rspValid === 1'b1) begin
      if (expQ.size() == 0) check("spare response", 1, 0);
      else check("rspData", rspData, expQ.pop_front());
    end
  end
  initial begin
    #100us;
    num_errors++;
    close_out();
  end
  initial begin
    logic [16:0] a;
    void'($urandom(85705));
    repeat (5) @(posedge clock);
    check("select low during reset", selN, 1);
    check("drive during reset", dataOe, 0);
    nrst <= 1;
    req(1, 17'h0_0000, 8'h5a);
    req(1, 17'h1_ffff, 8'ha5);
    req(0, 17'h0_0000, 8'h00);
    req(0, 17'h1_ffff, 8'h00);
    req(1, 17'h1_ffff, 8'h3c);
    req(0, 17'h1_ffff, 8'h00);
    for (int i = 0; i < 40; i++) begin
      a = 17'($urandom());
      if (i % 3 == 2) req(0, used[$urandom() % used.size()], 8'h00);
      else req(1, a, 8'($urandom()));
    end
    idle(15);
    check("selected when idle", selN, 1);
    supplyLow <= 1;
    repeat (20) @(posedge clock);
    @(negedge clock) check("ready with supply low", reqReady, 0);
    fork
      begin
        repeat (10) @(posedge clock);
        supplyLow <= 0;
      end
    join_none
    foreach (used[i]) req(0, used[i], 8'h00);
    idle(1);
    for (int n = 0; n < 40 && expQ.size() > 0; n++) @(posedge clock);
    check("responses left", expQ.size(), 0);
    check("memory timing fault", fault, 0);
    close_out();
  end
endmodule // tb_sram_host
